// ### oag_top.sv
// Purpose: operand effective address generator of a 16-bit signal processor
// Assumes: decode logic presents one request per cycle with its second word
// Notes:   accumulator pointer strobe leads the address by one cycle
//          an external register load wins over a post modification writeback
//          eff_addr and test_flag hold their last value between address strobes
//          decode_error marks a non-zero modifier in direct, long relative or index relative mode
//          the base register is read before the writeback of the same edge
`timescale 1ns/100ps
module oag_top (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        req_valid,
	input  wire logic [16:0] opcode,
	input  wire logic [15:0] second_word,
	input  wire logic        is_flag_instr,
	input  wire logic        has_next_a,
	input  wire logic        byte_operand,
	input  wire logic        reg_load_en,
	input  wire logic [2:0]  reg_load_sel,
	input  wire logic [15:0] reg_load_data,
	input  wire logic [2:0]  reg_peek_sel,
	output logic      [15:0] reg_peek_data,
	output logic             ap_pre_inc,
	output logic             ap_pre_dec,
	output logic             string_mode,
	output logic             ea_valid,
	output logic      [15:0] eff_addr,
	output logic             flag_access,
	output logic      [5:0]  test_flag,
	output logic             decode_error
);

	////////////////////////////////////////////////////////////////////////////
	// declarations

	oag_dec_if dec_bus ();

	logic [15:0] base_data;
	logic [15:0] index_register;
	logic [15:0] page_register;
	logic [15:0] peek_data;
	logic [15:0] direct_address_word;
	logic [15:0] long_offset_word;
	logic [15:0] short_offset;
	logic [15:0] flag_rel_offset;
	logic [15:0] global_flag_address;
	logic [15:0] post_step;
	logic [15:0] ea_d;
	logic [15:0] wb_data;
	logic        wb_en;
	logic        flag_mode;

	logic        s1_valid_q;
	logic [15:0] s1_addr_q;
	logic        s1_flag_q;
	logic [5:0]  s1_flag_bit_q;
	logic        s1_err_q;
	logic        ap_inc_q;
	logic        ap_dec_q;
	logic        string_q;
	logic        ea_valid_q;
	logic [15:0] eff_addr_q;
	logic        flag_access_q;
	logic [5:0]  test_flag_q;
	logic        decode_error_q;
	logic [15:0] reg_peek_q;

	////////////////////////////////////////////////////////////////////////////
	// helper functions

	// post modification step size, registers hold byte addresses
	function automatic logic [15:0] step_size(input logic is_byte);
		logic [15:0] s;
		s = oag_pkg::OAG_WORD_STEP;
		if (is_byte) begin
			s = oag_pkg::OAG_BYTE_STEP;
		end
		return s;
	endfunction

	// true for the two flag addressing modes
	function automatic logic is_flag_mode(input oag_pkg::oag_mode_t m);
		return (m == oag_pkg::OAG_MODE_FLAG_GLOBAL) || (m == oag_pkg::OAG_MODE_FLAG_REL);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// submodules

	// opcode field decode
	oag_mode_decode u_decode (
		.opcode        (opcode),
		.is_flag_instr (is_flag_instr),
		.has_next_a    (has_next_a),
		.d             (dec_bus.dec)
	);

	// address register file with post modification writeback
	oag_addr_regs u_regs (
		.clock      (clock),
		.rst_n      (rst_n),
		.base_sel   (dec_bus.rx_sel),
		.base_data  (base_data),
		.index_data (index_register),
		.page_data  (page_register),
		.peek_sel   (reg_peek_sel),
		.peek_data  (peek_data),
		.wb_en      (wb_en),
		.wb_sel     (dec_bus.rx_sel),
		.wb_data    (wb_data),
		.ld_en      (reg_load_en),
		.ld_sel     (reg_load_sel),
		.ld_data    (reg_load_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// operand forms

	// the second word serves as address or as long offset depending on mode
	assign direct_address_word = second_word;
	assign long_offset_word    = second_word;

	// zero extended short forms
	assign short_offset        = {9'h000, dec_bus.short_offset};
	assign global_flag_address = {9'h000, dec_bus.flag_offset, 1'b0};
	assign flag_rel_offset     = {9'h000, dec_bus.flag_offset, 1'b0};
	assign post_step           = step_size(byte_operand);
	assign flag_mode           = is_flag_mode(dec_bus.mode);

	////////////////////////////////////////////////////////////////////////////
	// effective address, all sums are 16 bits and wrap

	always_comb begin
		ea_d = oag_pkg::OAG_ADDR_RST;
		case (dec_bus.mode)
			oag_pkg::OAG_MODE_DIRECT: begin
				ea_d = direct_address_word;
			end
			oag_pkg::OAG_MODE_LONG_REL: begin
				ea_d = base_data + long_offset_word;
			end
			oag_pkg::OAG_MODE_INDEX_REL: begin
				ea_d = base_data + index_register;
			end
			oag_pkg::OAG_MODE_INDIRECT: begin
				ea_d = base_data;
			end
			oag_pkg::OAG_MODE_SHORT_REL: begin
				ea_d = page_register + short_offset;
			end
			oag_pkg::OAG_MODE_FLAG_GLOBAL: begin
				ea_d = oag_pkg::OAG_FLAG_BASE + global_flag_address;
			end
			oag_pkg::OAG_MODE_FLAG_REL: begin
				ea_d = page_register + flag_rel_offset;
			end
			default: begin
				ea_d = oag_pkg::OAG_ADDR_RST;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// post modification, only indirect mode writes the base register back

	// writeback happens at the request edge so a following request sees it
	assign wb_en = req_valid && (dec_bus.post_mod != oag_pkg::OAG_POST_NONE);

	always_comb begin
		wb_data = base_data;
		case (dec_bus.post_mod)
			oag_pkg::OAG_POST_INC:   wb_data = base_data + post_step;
			oag_pkg::OAG_POST_DEC:   wb_data = base_data - post_step;
			oag_pkg::OAG_POST_INDEX: wb_data = base_data + index_register;
			default:                 wb_data = base_data;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// stage one: capture address, issue pointer premodify strobes

	// request strobe and the address formed from it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_valid_q <= 1'b0;
			s1_addr_q  <= oag_pkg::OAG_ADDR_RST;
		end else begin
			s1_valid_q <= req_valid;
			s1_addr_q  <= req_valid ? ea_d : s1_addr_q;
		end
	end

	// flag marker and flag bit number, the bit number is held between requests
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_flag_q     <= 1'b0;
			s1_flag_bit_q <= 6'h00;
		end else begin
			s1_flag_q     <= req_valid && flag_mode;
			s1_flag_bit_q <= req_valid ? dec_bus.flag_offset : s1_flag_bit_q;
		end
	end

	// modifier coding error, a diagnostic only, the address is still formed
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_err_q <= 1'b0;
		end else begin
			s1_err_q <= req_valid && dec_bus.bad_pm;
		end
	end

	// pointer step strobes one cycle ahead of the operand address
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ap_inc_q <= 1'b0;
			ap_dec_q <= 1'b0;
		end else begin
			ap_inc_q <= req_valid && (dec_bus.ap_mod == oag_pkg::OAG_AP_INC);
			ap_dec_q <= req_valid && (dec_bus.ap_mod == oag_pkg::OAG_AP_DEC);
		end
	end

	// string mode marker with the same timing as the step strobes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			string_q <= 1'b0;
		end else begin
			string_q <= req_valid && (dec_bus.ap_mod == oag_pkg::OAG_AP_STRING);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// stage two: present the operand address after the pointer has moved

	// address strobe and the address it carries, held between strobes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ea_valid_q <= 1'b0;
			eff_addr_q <= oag_pkg::OAG_ADDR_RST;
		end else begin
			ea_valid_q <= s1_valid_q;
			eff_addr_q <= s1_valid_q ? s1_addr_q : eff_addr_q;
		end
	end

	// flag marker and flag bit number presented with the address
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flag_access_q <= 1'b0;
			test_flag_q   <= 6'h00;
		end else begin
			flag_access_q <= s1_valid_q && s1_flag_q;
			test_flag_q   <= s1_valid_q ? s1_flag_bit_q : test_flag_q;
		end
	end

	// modifier coding error presented with the address
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			decode_error_q <= 1'b0;
		end else begin
			decode_error_q <= s1_valid_q && s1_err_q;
		end
	end

	// registered view of any address register for debug and context save
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_peek_q <= oag_pkg::OAG_REG_RST;
		end else begin
			reg_peek_q <= peek_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign ap_pre_inc    = ap_inc_q;
	assign ap_pre_dec    = ap_dec_q;
	assign string_mode   = string_q;
	assign ea_valid      = ea_valid_q;
	assign eff_addr      = eff_addr_q;
	assign flag_access   = flag_access_q;
	assign test_flag     = test_flag_q;
	assign decode_error  = decode_error_q;
	assign reg_peek_data = reg_peek_q;

endmodule // oag_top

// ### oag_pkg.sv
// Purpose: constants and types shared by the operand address generator
// Assumes: 17-bit opcode word, 16-bit byte addresses, eight address registers
// Notes:   every field position, reset value and step size is named here once
package oag_pkg;

	////////////////////////////////////////////////////////////////////////////
	// widths
	localparam int OAG_OPW  = 17;              // opcode word width
	localparam int OAG_AW   = 16;              // address and register width
	localparam int OAG_NREG = 8;               // number of address registers
	localparam int OAG_SELW = 3;               // register select width

	////////////////////////////////////////////////////////////////////////////
	// opcode field positions
	localparam int OAG_AM_MSB    = 7;          // mode select field
	localparam int OAG_AM_LSB    = 5;
	localparam int OAG_RX_MSB    = 4;          // register select field
	localparam int OAG_RX_LSB    = 2;
	localparam int OAG_PM_MSB    = 1;          // post modification field
	localparam int OAG_PM_LSB    = 0;
	localparam int OAG_SHORT_BIT = 7;          // set selects short relative
	localparam int OAG_OFF7_MSB  = 6;          // short offset b6..b0
	localparam int OAG_FLAG_MSB  = 6;          // flag address bits 6..1
	localparam int OAG_FLAG_LSB  = 1;
	localparam int OAG_FLAG_GR   = 0;          // global (0) or relative (1)
	localparam int OAG_NEXTA_MSB = 11;         // accumulator pointer field
	localparam int OAG_NEXTA_LSB = 10;

	////////////////////////////////////////////////////////////////////////////
	// field codes
	localparam logic [2:0] OAG_AM_DIRECT   = 3'h0;
	localparam logic [2:0] OAG_AM_LONG     = 3'h1;
	localparam logic [2:0] OAG_AM_INDEX    = 3'h2;
	localparam logic [2:0] OAG_AM_INDIRECT = 3'h3;
	localparam logic [1:0] OAG_PM_NONE     = 2'h0;
	localparam logic [1:0] OAG_PM_INC      = 2'h1;
	localparam logic [1:0] OAG_PM_DEC      = 2'h2;
	localparam logic [1:0] OAG_PM_IDX      = 2'h3;
	localparam logic [1:0] OAG_NA_NONE     = 2'h0;
	localparam logic [1:0] OAG_NA_DEC      = 2'h1;
	localparam logic [1:0] OAG_NA_INC      = 2'h2;
	localparam logic [1:0] OAG_NA_STRING   = 2'h3;

	////////////////////////////////////////////////////////////////////////////
	// fixed registers, bases, steps and reset values
	localparam logic [2:0]  OAG_INDEX_SEL = 3'h5;
	localparam logic [2:0]  OAG_PAGE_SEL  = 3'h6;
	localparam logic [15:0] OAG_FLAG_BASE = 16'h0000;
	localparam logic [15:0] OAG_WORD_STEP = 16'h0002;
	localparam logic [15:0] OAG_BYTE_STEP = 16'h0001;
	localparam logic [15:0] OAG_REG_RST   = 16'h0000;
	localparam logic [15:0] OAG_ADDR_RST  = 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// decoded types
	typedef enum logic [2:0] {
		OAG_MODE_DIRECT,
		OAG_MODE_LONG_REL,
		OAG_MODE_INDEX_REL,
		OAG_MODE_INDIRECT,
		OAG_MODE_SHORT_REL,
		OAG_MODE_FLAG_GLOBAL,
		OAG_MODE_FLAG_REL
	} oag_mode_t;

	typedef enum logic [1:0] {
		OAG_POST_NONE,
		OAG_POST_INC,
		OAG_POST_DEC,
		OAG_POST_INDEX
	} oag_post_t;

	typedef enum logic [1:0] {
		OAG_AP_NONE,
		OAG_AP_DEC,
		OAG_AP_INC,
		OAG_AP_STRING
	} oag_ap_t;

endpackage

// ### oag_dec_if.sv
// Purpose: decoded addressing fields passed from decoder to address path
// Assumes: one decoder drives, the address path reads
// Notes:   purely combinational bundle
`timescale 1ns/100ps
interface oag_dec_if;
	oag_pkg::oag_mode_t mode;
	logic [2:0]         rx_sel;
	oag_pkg::oag_post_t post_mod;
	oag_pkg::oag_ap_t   ap_mod;
	logic [6:0]         short_offset;
	logic [5:0]         flag_offset;
	logic               bad_pm;

	modport dec (output mode, rx_sel, post_mod, ap_mod, short_offset, flag_offset, bad_pm);
	modport use_side (input mode, rx_sel, post_mod, ap_mod, short_offset, flag_offset, bad_pm);
endinterface // oag_dec_if

// ### oag_mode_decode.sv
// Purpose: decode the opcode addressing bits into mode, register and modifiers
// Assumes: opcode is stable while it is being decoded
// Notes:   combinational only
`timescale 1ns/100ps
module oag_mode_decode (
	input  wire logic [16:0] opcode,
	input  wire logic        is_flag_instr,
	input  wire logic        has_next_a,
	oag_dec_if.dec           d
);

	logic [2:0] mode_select_field;
	logic [1:0] post_mod_field;
	logic [1:0] next_a_field;

	// field extraction from the low opcode byte and the pointer field
	assign mode_select_field = opcode[oag_pkg::OAG_AM_MSB:oag_pkg::OAG_AM_LSB];
	assign post_mod_field    = opcode[oag_pkg::OAG_PM_MSB:oag_pkg::OAG_PM_LSB];
	assign next_a_field      = opcode[oag_pkg::OAG_NEXTA_MSB:oag_pkg::OAG_NEXTA_LSB];
	assign d.rx_sel          = opcode[oag_pkg::OAG_RX_MSB:oag_pkg::OAG_RX_LSB];
	assign d.short_offset    = opcode[oag_pkg::OAG_OFF7_MSB:0];
	assign d.flag_offset     = opcode[oag_pkg::OAG_FLAG_MSB:oag_pkg::OAG_FLAG_LSB];

	// mode selection, flag instructions take precedence over the byte fields
	always_comb begin
		d.mode = oag_pkg::OAG_MODE_DIRECT;
		if (is_flag_instr) begin
			if (opcode[oag_pkg::OAG_FLAG_GR]) begin
				d.mode = oag_pkg::OAG_MODE_FLAG_REL;
			end else begin
				d.mode = oag_pkg::OAG_MODE_FLAG_GLOBAL;
			end
		end else if (opcode[oag_pkg::OAG_SHORT_BIT]) begin
			d.mode = oag_pkg::OAG_MODE_SHORT_REL;
		end else begin
			case (mode_select_field)
				oag_pkg::OAG_AM_DIRECT:   d.mode = oag_pkg::OAG_MODE_DIRECT;
				oag_pkg::OAG_AM_LONG:     d.mode = oag_pkg::OAG_MODE_LONG_REL;
				oag_pkg::OAG_AM_INDEX:    d.mode = oag_pkg::OAG_MODE_INDEX_REL;
				oag_pkg::OAG_AM_INDIRECT: d.mode = oag_pkg::OAG_MODE_INDIRECT;
				default:                  d.mode = oag_pkg::OAG_MODE_DIRECT;
			endcase
		end
	end

	// post modification only exists for indirect mode
	always_comb begin
		d.post_mod = oag_pkg::OAG_POST_NONE;
		d.bad_pm   = 1'b0;
		if (d.mode == oag_pkg::OAG_MODE_INDIRECT) begin
			case (post_mod_field)
				oag_pkg::OAG_PM_INC: d.post_mod = oag_pkg::OAG_POST_INC;
				oag_pkg::OAG_PM_DEC: d.post_mod = oag_pkg::OAG_POST_DEC;
				oag_pkg::OAG_PM_IDX: d.post_mod = oag_pkg::OAG_POST_INDEX;
				default:             d.post_mod = oag_pkg::OAG_POST_NONE;
			endcase
		end else if (!is_flag_instr && !opcode[oag_pkg::OAG_SHORT_BIT]) begin
			d.bad_pm = (post_mod_field != oag_pkg::OAG_PM_NONE); // must be coded zero
		end
	end

	// accumulator pointer field, honoured only for classes that carry it
	always_comb begin
		d.ap_mod = oag_pkg::OAG_AP_NONE;
		if (has_next_a) begin
			case (next_a_field)
				oag_pkg::OAG_NA_DEC:    d.ap_mod = oag_pkg::OAG_AP_DEC;
				oag_pkg::OAG_NA_INC:    d.ap_mod = oag_pkg::OAG_AP_INC;
				oag_pkg::OAG_NA_STRING: d.ap_mod = oag_pkg::OAG_AP_STRING;
				default:                d.ap_mod = oag_pkg::OAG_AP_NONE;
			endcase
		end
	end

endmodule // oag_mode_decode

// ### oag_addr_regs.sv
// Purpose: eight 16-bit address registers with load and writeback ports
// Assumes: load and writeback may hit the same register in one cycle
// Notes:   an external load beats a post modification writeback
`timescale 1ns/100ps
module oag_addr_regs (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [2:0]  base_sel,
	output logic      [15:0] base_data,
	output logic      [15:0] index_data,
	output logic      [15:0] page_data,
	input  wire logic [2:0]  peek_sel,
	output logic      [15:0] peek_data,
	input  wire logic        wb_en,
	input  wire logic [2:0]  wb_sel,
	input  wire logic [15:0] wb_data,
	input  wire logic        ld_en,
	input  wire logic [2:0]  ld_sel,
	input  wire logic [15:0] ld_data
);

	logic [15:0] regs_q [oag_pkg::OAG_NREG];

	// one register per generate slice, load first then writeback
	for (genvar i = 0; i < oag_pkg::OAG_NREG; i++) begin : g_reg
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				regs_q[i] <= oag_pkg::OAG_REG_RST;
			end else if (ld_en && (ld_sel == 3'(i))) begin
				regs_q[i] <= ld_data;
			end else if (wb_en && (wb_sel == 3'(i))) begin
				regs_q[i] <= wb_data;
			end
		end
	end

	// read ports
	assign base_data  = regs_q[base_sel];
	assign index_data = regs_q[oag_pkg::OAG_INDEX_SEL];
	assign page_data  = regs_q[oag_pkg::OAG_PAGE_SEL];
	assign peek_data  = regs_q[peek_sel];

endmodule // oag_addr_regs

// ### oag_checker.sv
// Purpose: port checks on the operand address generator
// Assumes: fixed two-stage request pipeline, one clock domain
// Notes:   attached to oag_top by the bind at the foot of this file
`timescale 1ns/100ps
module oag_checker (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        req_valid,
	input wire logic [16:0] opcode,
	input wire logic [15:0] second_word,
	input wire logic        is_flag_instr,
	input wire logic        has_next_a,
	input wire logic        ap_pre_inc,
	input wire logic        ap_pre_dec,
	input wire logic        string_mode,
	input wire logic        ea_valid,
	input wire logic [15:0] eff_addr,
	input wire logic        flag_access,
	input wire logic [5:0]  test_flag,
	input wire logic        decode_error
);
	////////////////////////////////////////////////////////////////////////
	logic [16:0] op1_q, op2_q;
	logic [15:0] sw1_q, sw2_q;
	logic        fl1_q, fl2_q;

	// request fields follow the pipeline to the address stage
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			op1_q <= '0;
			op2_q <= '0;
			sw1_q <= '0;
			sw2_q <= '0;
			fl1_q <= 1'b0;
			fl2_q <= 1'b0;
		end else begin
			op1_q <= opcode;
			op2_q <= op1_q;
			sw1_q <= second_word;
			sw2_q <= sw1_q;
			fl1_q <= is_flag_instr;
			fl2_q <= fl1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence ptr_step_s; ap_pre_inc || ap_pre_dec; endsequence
	sequence access_s; ea_valid; endsequence

	ea_latency_a: assert property (req_valid |-> ##2 ea_valid)
		else $error("address strobe not two cycles after request");
	ea_cause_a: assert property (ea_valid |-> $past(req_valid, 2))
		else $error("address strobe without request");
	ptr_inc_a: assert property (req_valid && has_next_a && opcode[11:10] == 2'h2 |=>
		ap_pre_inc && !ap_pre_dec) else $error("pointer increment missing");
	ptr_dec_a: assert property (req_valid && has_next_a && opcode[11:10] == 2'h1 |=>
		ap_pre_dec && !ap_pre_inc) else $error("pointer decrement missing");
	ptr_ignored_a: assert property (req_valid && !has_next_a |=>
		!(ap_pre_inc || ap_pre_dec || string_mode)) else $error("pointer field not ignored");
	pre_first_a: assert property (ptr_step_s |=> access_s)
		else $error("pointer step not ahead of access");
	direct_addr_a: assert property (ea_valid && !fl2_q && op2_q[7:5] == 3'h0 |->
		eff_addr == sw2_q) else $error("direct address wrong");
	flag_global_a: assert property (ea_valid && fl2_q && !op2_q[0] |-> flag_access &&
		test_flag == op2_q[6:1] && eff_addr == {9'h000, op2_q[6:1], 1'b0})
		else $error("global flag address wrong");
	addr_hold_a: assert property (!ea_valid |-> $stable(eff_addr))
		else $error("address changed without strobe");
	pm_error_a: assert property (ea_valid && !fl2_q && !op2_q[7] && op2_q[6:5] != 2'h3 |->
		decode_error == (op2_q[1:0] != 2'h0)) else $error("modifier error flag wrong");
endmodule // oag_checker

bind oag_top oag_checker chk_u (
	.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .opcode(opcode),
	.second_word(second_word), .is_flag_instr(is_flag_instr), .has_next_a(has_next_a),
	.ap_pre_inc(ap_pre_inc), .ap_pre_dec(ap_pre_dec), .string_mode(string_mode),
	.ea_valid(ea_valid), .eff_addr(eff_addr), .flag_access(flag_access),
	.test_flag(test_flag), .decode_error(decode_error)
);

// ### oag_decode_model.sv
// Purpose: instruction decode side that presents addressing requests
// Assumes: fields change just after a rising edge
// Notes:   released opcode and second word are inverted so stale values never look valid
`timescale 1ns/100ps
module oag_decode_model (
	input  wire logic        clock,
	output logic             req_valid,
	output logic      [16:0] opcode,
	output logic      [15:0] second_word,
	output logic             is_flag_instr,
	output logic             has_next_a,
	output logic             byte_operand
);
	// quiet bus at time zero
	initial begin
		req_valid = 1'b0;
		opcode = 17'h00000;
		second_word = 16'h0000;
		is_flag_instr = 1'b0;
		has_next_a = 1'b0;
		byte_operand = 1'b0;
	end

	// one request per cycle, second word in the same cycle
	task automatic send(input logic [16:0] op, input logic [15:0] sw, input logic fl,
		input logic na, input logic bo);
		@(posedge clock);
		#1;
		req_valid = 1'b1;
		opcode = op;
		second_word = sw;
		is_flag_instr = fl;
		has_next_a = na;
		byte_operand = bo;
	endtask

	// drop the strobe and scramble the released opcode and second word
	task automatic idle();
		@(posedge clock);
		#1;
		req_valid = 1'b0;
		opcode = ~opcode;
		second_word = ~second_word;
	endtask
endmodule // oag_decode_model

// ### operand_address_generator_tb_top.sv
// Purpose: self-checking bench for the operand address generator
// Assumes: two-cycle address latency, one-cycle pointer strobe latency
// Notes:   a pipelined reference model checks every cycle
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_checks++; if ((ex) !== (gt)) begin failures++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module operand_address_generator_tb_top;
	typedef struct packed {
		logic v; logic [15:0] a; logic fl; logic err; logic [5:0] tf;
		logic inc; logic dec; logic str;
	} oag_exp_t;
	logic        clock, rst_n, reg_load_en, req_valid, is_flag_instr, has_next_a, byte_operand;
	logic [2:0]  reg_load_sel, reg_peek_sel;
	logic [15:0] reg_load_data, second_word, reg_peek_data, eff_addr, hold, pk_exp;
	logic [16:0] opcode;
	logic        ap_pre_inc, ap_pre_dec, string_mode, ea_valid, flag_access, decode_error;
	logic [5:0]  test_flag;
	logic [15:0] mr [8];
	oag_exp_t    pq [$];
	int          failures = 0;
	int          n_checks = 0;

	////////////////////////////////////////////////////////////////////////
	oag_decode_model dm_u (.clock(clock), .req_valid(req_valid), .opcode(opcode),
		.second_word(second_word), .is_flag_instr(is_flag_instr), .has_next_a(has_next_a),
		.byte_operand(byte_operand));
	oag_top dut_u (.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .opcode(opcode),
		.second_word(second_word), .is_flag_instr(is_flag_instr), .has_next_a(has_next_a),
		.byte_operand(byte_operand), .reg_load_en(reg_load_en), .reg_load_sel(reg_load_sel),
		.reg_load_data(reg_load_data), .reg_peek_sel(reg_peek_sel),
		.reg_peek_data(reg_peek_data), .ap_pre_inc(ap_pre_inc), .ap_pre_dec(ap_pre_dec),
		.string_mode(string_mode), .ea_valid(ea_valid), .eff_addr(eff_addr),
		.flag_access(flag_access), .test_flag(test_flag), .decode_error(decode_error));

	// 40 MHz clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////
	// reference model: check outputs, then step the model as the edge will
	always @(negedge clock) begin : mon_b
		oag_exp_t    e, s;
		logic [15:0] b, nb, st;
		if (!rst_n) begin
			pq.delete();
			foreach (mr[i]) mr[i] = 16'h0000;
			hold = 16'h0000;
			pk_exp = 16'h0000;
		end else begin
			`CHK("reg_peek_data", pk_exp, reg_peek_data)
			if (pq.size() > 0) begin
				s = pq[$];
				`CHK("ap_pre_inc", s.inc, ap_pre_inc)
				`CHK("ap_pre_dec", s.dec, ap_pre_dec)
				`CHK("string_mode", s.str, string_mode)
			end
			if (pq.size() == 2) begin
				s = pq.pop_front();
				if (s.v) hold = s.a;
				`CHK("ea_valid", s.v, ea_valid)
				`CHK("eff_addr", hold, eff_addr)
				`CHK("flag_access", s.v & s.fl, flag_access)
				`CHK("decode_error", s.v & s.err, decode_error)
				if (s.v && s.fl) `CHK("test_flag", s.tf, test_flag)
			end
			e = '0;
			b = mr[opcode[4:2]];
			nb = b;
			st = byte_operand ? 16'h0001 : 16'h0002;
			if (has_next_a) begin
				e.dec = opcode[11:10] == 2'h1;
				e.inc = opcode[11:10] == 2'h2;
				e.str = opcode[11:10] == 2'h3;
			end
			if (is_flag_instr) begin
				e.fl = 1'b1;
				e.tf = opcode[6:1];
				e.a = {9'h000, opcode[6:1], 1'b0} + (opcode[0] ? mr[6] : 16'h0000);
			end else if (opcode[7]) begin
				e.a = mr[6] + {9'h000, opcode[6:0]};
			end else begin
				e.err = opcode[6:5] != 2'h3 && opcode[1:0] != 2'h0;
				case (opcode[6:5])
					2'h0: e.a = second_word;
					2'h1: e.a = b + second_word;
					2'h2: e.a = b + mr[5];
					default: begin
						e.a = b;
						if (opcode[1:0] == 2'h1) nb = b + st;
						if (opcode[1:0] == 2'h2) nb = b - st;
						if (opcode[1:0] == 2'h3) nb = b + mr[5];
					end
				endcase
			end
			pk_exp = mr[reg_peek_sel];
			if (req_valid) begin
				e.v = 1'b1;
				if (!is_flag_instr) mr[opcode[4:2]] = nb;
			end else begin
				e = '0;
			end
			if (reg_load_en) mr[reg_load_sel] = reg_load_data;
			pq.push_back(e);
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic ld(input logic [2:0] sel, input logic [15:0] dat);
		@(posedge clock);
		#1;
		reg_load_en = 1'b1;
		reg_load_sel = sel;
		reg_load_data = dat;
		@(posedge clock);
		#1;
		reg_load_en = 1'b0;
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// watchdog well beyond the expected run
	initial begin
		#(3000 * 25);
		failures++;
		end_of_test();
	end

	// reset, directed cases, then random traffic with loads
	initial begin
		rst_n = 1'b0;
		reg_load_en = 1'b0;
		reg_load_sel = 3'h0;
		reg_load_data = 16'h0000;
		reg_peek_sel = 3'h6;
		void'($urandom(23));
		repeat (3) @(posedge clock);
		#1;
		rst_n = 1'b1;
		ld(3'h1, 16'h0200);
		ld(3'h5, 16'h0002);
		ld(3'h6, 16'h03E4);
		dm_u.send(17'h00865, 16'h0000, 1'b0, 1'b1, 1'b0);
		dm_u.send(17'h00865, 16'h0000, 1'b0, 1'b1, 1'b1);
		dm_u.send(17'h00067, 16'h0000, 1'b0, 1'b0, 1'b0);
		dm_u.send(17'h00042, 16'h0000, 1'b0, 1'b0, 1'b0);
		dm_u.send(17'h00024, 16'hFF00, 1'b0, 1'b0, 1'b0);
		dm_u.send(17'h000FF, 16'h0000, 1'b0, 1'b0, 1'b0);
		dm_u.send(17'h0007E, 16'h0000, 1'b1, 1'b0, 1'b0);
		dm_u.send(17'h0007F, 16'h0000, 1'b1, 1'b0, 1'b0);
		dm_u.idle();
		repeat (700) begin
			dm_u.send(17'($urandom), 16'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
			reg_load_en = $urandom_range(3) == 0;
			reg_load_sel = 3'($urandom);
			reg_load_data = 16'($urandom);
			reg_peek_sel = 3'($urandom);
			if ($urandom_range(4) == 0) dm_u.idle();
		end
		dm_u.idle();
		repeat (4) @(posedge clock);
		end_of_test();
	end
endmodule // operand_address_generator_tb_top
